//--- src/qpd_regs.svh
// register indices, field positions, reset values and limits of the pulse divider
// assumes a 32-bit classic wishbone bus; byte address is four times an index
`ifndef QPD_REGS_SVH
`define QPD_REGS_SVH
// register indices (byte address = index * 4)
`define QPD_IDX_DIV 30'h0000731F
`define QPD_IDX_FILT 30'h00007320
`define QPD_IDX_STEP 30'h00007321
`define QPD_IDX_STAT 30'h00007322
// reset values
`define QPD_DIV_RST 16'h0001
`define QPD_FILT_RST 16'h0000
// setting decode and limits
`define QPD_THOUSAND 16'h03E8
`define QPD_M_MIN 16'h0001
`define QPD_M_MAX 16'h0080
`define QPD_N1_LO 16'h03EA
`define QPD_DIV_MAX 16'h0468
`define QPD_FILT_MAX 16'h000F
// step register bits
`define QPD_STEP_UP_BIT 0
`define QPD_STEP_DN_BIT 1
// status register fields
`define QPD_ST_IN_A_BIT 0
`define QPD_ST_IN_B_BIT 1
`define QPD_ST_OUT_A_BIT 2
`define QPD_ST_OUT_B_BIT 3
`define QPD_ST_REJ_BIT 4
`define QPD_ST_ACC_LSB 16
`endif

//--- src/qpd_pkg.sv
// types shared by the pulse divider modules
// assumes qpd_regs.svh carries every numeric constant
package qpd_pkg;
  // one sample of the two encoder phases
  typedef struct packed {
    logic a;
    logic b;
  } qpd_quad_t;
  // movement seen between two phase samples
  typedef enum logic [1:0] {
    QPD_MOVE_NONE = 2'b00,
    QPD_MOVE_FWD = 2'b01,
    QPD_MOVE_REV = 2'b10,
    QPD_MOVE_BAD = 2'b11
  } qpd_move_t;
endpackage : qpd_pkg

//--- src/qpd_glitch_filter.sv
// glitch filter for one synchronised phase input
// assumes din_i is already on clk_i (two flops in front of it)
`timescale 1ns/1ps
module qpd_glitch_filter #(
  parameter int CNT_W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic din_i,
  input wire logic [CNT_W-1:0] len_i,
  output logic dout_o
);
  initial
  begin
    if (CNT_W < 1) $error("qpd_glitch_filter: CNT_W must be at least 1");
  end

  logic dout_ff; // accepted level
  logic nxt_dout;
  logic [CNT_W-1:0] cnt_ff; // cycles the new level has held
  logic [CNT_W-1:0] nxt_cnt;

  // a change is taken once it has held len_i cycles; zero takes it at once
  always_comb
  begin
    nxt_dout = dout_ff;
    nxt_cnt = '0;
    if (din_i != dout_ff)
    begin
      if (cnt_ff >= len_i)
      begin
        nxt_dout = din_i;
      end
      else
      begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  // registers only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dout_ff <= 1'b0;
      cnt_ff <= '0;
    end
    else
    begin
      dout_ff <= nxt_dout;
      cnt_ff <= nxt_cnt;
    end
  end

  assign dout_o = dout_ff;
endmodule : qpd_glitch_filter

//--- src/qpd_top.sv
// quadrature pulse divider: filters A/B phases, divides by M/(1+N), drives A/B out
// assumes a classic wishbone master on clk_i and asynchronous encoder pin inputs
`timescale 1ns/1ps
`include "qpd_regs.svh"
module qpd_top
  import qpd_pkg::*;
#(
  parameter int FILT_W = 4,
  parameter int ACC_W = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // encoder phases in, divided phases out
  input wire logic phase_a_input_i,
  input wire logic phase_b_input_i,
  output logic divided_phase_a_out_o,
  output logic divided_phase_b_out_o
);
  // filter values reach 15 and the accumulator must hold +/-129
  initial
  begin
    if (FILT_W < 4) $error("qpd_top: FILT_W must be at least 4");
    if (ACC_W < 9) $error("qpd_top: ACC_W must be at least 9");
  end

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers and glitch filters
  ////////////////////////////////////////////////////////////////////////
  logic [1:0] pin_raw; // index 1 is phase A, 0 is phase B
  logic [1:0] sync1_ff; // first stage, read only by sync2_ff
  logic [1:0] sync2_ff; // second stage, safe to use
  logic [1:0] filt_bits; // filtered phases
  qpd_quad_t in_q; // filtered phases as a pair
  logic [15:0] filt_ff; // filter setting register
  logic [15:0] div_ff; // division setting register

  assign pin_raw = {phase_a_input_i, phase_b_input_i};

  // two flops per pin before anything looks at the level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
    end
    else
    begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
    end
  end

  // one filter per phase, both driven by the same setting
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_phase
      qpd_glitch_filter #(
        .CNT_W(FILT_W)
      ) u_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .din_i(sync2_ff[gi]),
        .len_i(filt_ff[FILT_W-1:0]),
        .dout_o(filt_bits[gi])
      );
    end
  endgenerate

  assign in_q = qpd_quad_t'(filt_bits);

  ////////////////////////////////////////////////////////////////////////
  // setting decode
  ////////////////////////////////////////////////////////////////////////
  logic set_n; // thousands digit, 0 or 1
  logic [15:0] set_m_w; // remainder below a thousand
  logic [7:0] set_m; // divisor, 1..128
  logic signed [ACC_W-1:0] step_k; // numerator, 1 or 2
  logic signed [ACC_W-1:0] step_m; // divisor, zero extended

  // value = N*1000 + M; stored values never leave the legal set
  always_comb
  begin
    set_n = (div_ff >= `QPD_THOUSAND);
    set_m_w = set_n ? (div_ff - `QPD_THOUSAND) : div_ff;
    set_m = set_m_w[7:0];
    step_k = set_n ? ACC_W'(2) : ACC_W'(1);
    step_m = ACC_W'(set_m);
  end

  // legal settings: M 1..128 with N=0, or M 2..128 with N=1 (ratio at most one)
  function automatic logic qpd_legal(input logic [15:0] v);
    qpd_legal = ((v >= `QPD_M_MIN) && (v <= `QPD_M_MAX)) ||
                ((v >= `QPD_N1_LO) && (v <= `QPD_DIV_MAX));
  endfunction : qpd_legal

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave and registers
  ////////////////////////////////////////////////////////////////////////
  logic ack_ff; // answer, one cycle after the request is seen
  logic nxt_ack;
  logic [31:0] dat_ff; // read data, stands with ack
  logic [31:0] nxt_dat;
  logic [15:0] nxt_div;
  logic [15:0] nxt_filt;
  logic rej_ff; // last setting or filter write was refused
  logic nxt_rej;
  logic div_chg; // setting changed, restart the accumulator
  logic req; // new request this cycle
  logic [29:0] idx; // word index of the access
  logic [15:0] wr_val; // byte-merged candidate value
  logic [15:0] wr_old; // register the write targets
  logic [15:0] stp_val; // setting after one step
  logic signed [ACC_W-1:0] acc_ff; // pulse accumulator
  logic [1:0] out_idx_ff; // output gray position

  assign req = cyc_i && stb_i && !ack_ff;
  assign idx = adr_i[31:2];

  // one step of the setting, skipping 129..1001 both ways
  always_comb
  begin
    stp_val = div_ff;
    if (dat_i[`QPD_STEP_UP_BIT] && sel_i[0])
    begin
      if (div_ff == `QPD_M_MAX)
      begin
        stp_val = `QPD_N1_LO;
      end
      else if (div_ff != `QPD_DIV_MAX)
      begin
        stp_val = div_ff + 16'h0001;
      end
    end
    else if (dat_i[`QPD_STEP_DN_BIT] && sel_i[0])
    begin
      if (div_ff == `QPD_N1_LO)
      begin
        stp_val = `QPD_M_MAX;
      end
      else if (div_ff != `QPD_M_MIN)
      begin
        stp_val = div_ff - 16'h0001;
      end
    end
  end

  // merge the written byte lanes into the current value
  always_comb
  begin
    wr_old = (idx == `QPD_IDX_FILT) ? filt_ff : div_ff;
    wr_val = wr_old;
    if (sel_i[0])
    begin
      wr_val[7:0] = dat_i[7:0];
    end
    if (sel_i[1])
    begin
      wr_val[15:8] = dat_i[15:8];
    end
  end

  // decode, write and read; unmapped words answer zero and drop writes
  always_comb
  begin
    nxt_ack = req;
    nxt_dat = 32'h00000000;
    nxt_div = div_ff;
    nxt_filt = filt_ff;
    nxt_rej = rej_ff;
    if (req && we_i)
    begin
      case (idx)
        `QPD_IDX_DIV:
        begin
          // out-of-range values are refused and the old one kept
          nxt_rej = !qpd_legal(wr_val);
          if (qpd_legal(wr_val))
          begin
            nxt_div = wr_val;
          end
        end
        `QPD_IDX_FILT:
        begin
          nxt_rej = (wr_val > `QPD_FILT_MAX);
          if (wr_val <= `QPD_FILT_MAX)
          begin
            nxt_filt = wr_val;
          end
        end
        `QPD_IDX_STEP:
        begin
          nxt_div = stp_val;
        end
        default:
        begin
          nxt_div = div_ff; // ignored
        end
      endcase
    end
    else if (req)
    begin
      case (idx)
        `QPD_IDX_DIV: nxt_dat = {16'h0000, div_ff};
        `QPD_IDX_FILT: nxt_dat = {16'h0000, filt_ff};
        `QPD_IDX_STAT:
        begin
          nxt_dat[`QPD_ST_IN_A_BIT] = in_q.a;
          nxt_dat[`QPD_ST_IN_B_BIT] = in_q.b;
          nxt_dat[`QPD_ST_OUT_A_BIT] = out_idx_ff[1];
          nxt_dat[`QPD_ST_OUT_B_BIT] = out_idx_ff[1] ^ out_idx_ff[0];
          nxt_dat[`QPD_ST_REJ_BIT] = rej_ff;
          nxt_dat[`QPD_ST_ACC_LSB +: ACC_W] = acc_ff;
        end
        default: nxt_dat = 32'h00000000;
      endcase
    end
  end

  assign div_chg = (nxt_div != div_ff);

  // bus and register flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
      div_ff <= `QPD_DIV_RST;
      filt_ff <= `QPD_FILT_RST;
      rej_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      div_ff <= nxt_div;
      filt_ff <= nxt_filt;
      rej_ff <= nxt_rej;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

  ////////////////////////////////////////////////////////////////////////
  // direction decode, division and output phase generation
  ////////////////////////////////////////////////////////////////////////
  qpd_quad_t prev_ff; // filtered phases one cycle ago
  logic [1:0] pos_now; // gray position of in_q
  logic [1:0] pos_old; // gray position of prev_ff
  qpd_move_t move; // what the input did this cycle
  logic signed [ACC_W-1:0] nxt_acc;
  logic signed [ACC_W-1:0] acc_sum;
  logic [1:0] nxt_out_idx;

  // position 0..3 along 00,01,11,10 (A,B); ascending is forward
  always_comb
  begin
    pos_now = {in_q.a, in_q.a ^ in_q.b};
    pos_old = {prev_ff.a, prev_ff.a ^ prev_ff.b};
    if (pos_now == pos_old)
    begin
      move = QPD_MOVE_NONE;
    end
    else if (pos_now == pos_old + 2'h1)
    begin
      move = QPD_MOVE_FWD;
    end
    else if (pos_now == pos_old - 2'h1)
    begin
      move = QPD_MOVE_REV;
    end
    else
    begin
      // both phases jumped at once: direction unknown, count nothing
      move = QPD_MOVE_BAD;
    end
  end

  // each forward input edge adds the numerator and each reverse one subtracts it; reaching +/-M gives one output edge,
  // so output pulses per input pulse equal (1+N)/M for every filtered input edge that moves one phase at a time
  always_comb
  begin
    nxt_acc = acc_ff;
    nxt_out_idx = out_idx_ff;
    acc_sum = acc_ff;
    case (move)
      QPD_MOVE_FWD:
      begin
        acc_sum = acc_ff + step_k;
        if (acc_sum >= step_m)
        begin
          nxt_acc = acc_sum - step_m;
          nxt_out_idx = out_idx_ff + 2'h1;
        end
        else
        begin
          nxt_acc = acc_sum;
        end
      end
      QPD_MOVE_REV:
      begin
        acc_sum = acc_ff - step_k;
        if (acc_sum <= -step_m)
        begin
          nxt_acc = acc_sum + step_m;
          nxt_out_idx = out_idx_ff - 2'h1;
        end
        else
        begin
          nxt_acc = acc_sum;
        end
      end
      default:
      begin
        nxt_acc = acc_ff;
      end
    endcase
    // a new divisor restarts the count so the remainder stays in range
    if (div_chg)
    begin
      nxt_acc = '0;
    end
  end

  // divider flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prev_ff <= '0;
      acc_ff <= '0;
      out_idx_ff <= 2'h0;
    end
    else
    begin
      prev_ff <= in_q;
      acc_ff <= nxt_acc;
      out_idx_ff <= nxt_out_idx;
    end
  end

  // gray position back to phases, same order as the input decode
  assign divided_phase_a_out_o = out_idx_ff[1];
  assign divided_phase_b_out_o = out_idx_ff[1] ^ out_idx_ff[0];
endmodule : qpd_top

//--- verif/qpd_checker.sv
// checker: bus timing and divided-phase relations of the pulse divider
// assumes it is bound into qpd_top and sees only its ports
`timescale 1ns/1ps
`include "qpd_regs.svh"
module qpd_checker #(
  parameter int FILT_W = 4,
  parameter int ACC_W = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic phase_a_input_i,
  input wire logic phase_b_input_i,
  input wire logic divided_phase_a_out_o,
  input wire logic divided_phase_b_out_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [1:0] pin_ff; // last pin sample
  logic [5:0] quiet_ff; // cycles since a pin moved, saturating
  logic [5:0] nxt_quiet;
  // an output step must trace back to a recent pin step (sync + widest filter)
  always_comb
  begin
    nxt_quiet = quiet_ff + {5'h00, quiet_ff != 6'h3F};
    if (rst_i || pin_ff != {phase_a_input_i, phase_b_input_i})
      nxt_quiet = 6'h00;
  end
  always_ff @(posedge clk_i)
  begin
    pin_ff <= {phase_a_input_i, phase_b_input_i};
    quiet_ff <= nxt_quiet;
  end
  // a read taken at one edge, answered at the next
  sequence rd_s(logic [29:0] idx);
    cyc_i && stb_i && !ack_o && !we_i && adr_i[31:2] == idx ##1 ack_o;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  ack_pulse_a:
    assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  ack_answer_a:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not answered");
  dat_idle_a:
    assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
  div_range_a:
    assert property (rd_s(`QPD_IDX_DIV) |-> dat_o[15:0] inside
      {[16'h0001:16'h0080], [16'h03EA:16'h0468]}) else $error("setting out of range");
  filt_range_a:
    assert property (rd_s(`QPD_IDX_FILT) |-> dat_o[15:0] <= 16'h000F)
      else $error("filter out of range");
  phase_step_a:
    assert property (!($changed(divided_phase_a_out_o) && $changed(divided_phase_b_out_o)))
      else $error("both divided phases moved");
  out_cause_a:
    assert property ($changed({divided_phase_a_out_o, divided_phase_b_out_o})
      |-> quiet_ff < 6'h18) else $error("output step without input step");
  reset_out_a:
    assert property ($fell(rst_i) |-> !divided_phase_a_out_o && !divided_phase_b_out_o)
      else $error("outputs not idle after reset");
endmodule : qpd_checker

bind qpd_top qpd_checker #(.FILT_W(FILT_W), .ACC_W(ACC_W)) chk_u (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .phase_a_input_i(phase_a_input_i),
  .phase_b_input_i(phase_b_input_i), .divided_phase_a_out_o(divided_phase_a_out_o),
  .divided_phase_b_out_o(divided_phase_b_out_o));

//--- verif/qpd_ctrl_model.sv
// controller model: follows the divided phases and keeps a signed position
// assumes the phases are levels that change at most one at a time
`timescale 1ns/1ps
module qpd_ctrl_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  output logic signed [15:0] pos_o
);
  logic [1:0] last_ff; // previous A,B sample
  logic signed [15:0] pos_ff; // steps counted so far
  logic signed [15:0] nxt_pos;
  assign pos_o = pos_ff;
  // order 00,01,11,10 counts up, the reverse counts down
  always_comb
  begin
    case ({last_ff, phase_a_i, phase_b_i})
      4'h1, 4'h7, 4'hE, 4'h8: nxt_pos = pos_ff + 16'sh0001;
      4'h2, 4'hB, 4'hD, 4'h4: nxt_pos = pos_ff - 16'sh0001;
      default: nxt_pos = pos_ff;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    last_ff <= rst_i ? 2'h0 : {phase_a_i, phase_b_i};
    pos_ff <= rst_i ? 16'sh0000 : nxt_pos;
  end
endmodule : qpd_ctrl_model

//--- verif/tb.sv
// testbench: register access over wishbone and encoder stepping through the divider
// assumes the controller model turns divided phases into a position count
`timescale 1ns/1ps
`include "qpd_regs.svh"
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, pa = 1'b0, pb = 1'b0, qa, qb;
  logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o, rd;
  logic [3:0] sel_i = 4'h0;
  logic signed [15:0] pos;
  logic [15:0] set_tab [5] = '{16'h0001, 16'h0003, 16'h0080, 16'h03EA, 16'h03EC};
  logic [15:0] bad_tab [5] = '{16'h0000, 16'h0081, 16'h03E8, 16'h03E9, 16'h0469};
  int n_errors = 0, n_compared = 0, p0, m, n1;
  always #12.5 clk_i = ~clk_i;
  qpd_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .phase_a_input_i(pa), .phase_b_input_i(pb), .divided_phase_a_out_o(qa),
    .divided_phase_b_out_o(qb));
  qpd_ctrl_model ctl_u (.clk_i(clk_i), .rst_i(rst_i), .phase_a_i(qa), .phase_b_i(qb),
    .pos_o(pos));
  // one classic cycle; held until ack is seen at an edge
  task automatic wb(input logic w, input logic [29:0] idx, input logic [15:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'h3;
    dat_i <= {16'h0000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic rc(input logic [29:0] idx, input logic [31:0] e, input string nm);
    wb(1'b0, idx, 16'h0000);
    chk(nm, e, rd);
  endtask : rc
  // n quadrature edges, gap + 1 cycles apart (gap above filter + 1)
  task automatic mv(input logic fwd, input int n, input int gap);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      pa <= fwd ? pb : ~pb;
      pb <= fwd ? ~pa : pa;
      repeat (gap) @(posedge clk_i);
    end
    repeat (30) @(posedge clk_i);
  endtask : mv
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(`QPD_IDX_DIV, 32'h1, "div reset");
    rc(`QPD_IDX_FILT, 32'h0, "filt reset");
    rc(30'h0, 32'h0, "unmapped");
    $display("reset test done");
    // each write of a new setting clears the accumulator, so 2*M edges give exact steps
    foreach (set_tab[i])
    begin
      n1 = set_tab[i] / 1000;
      m = set_tab[i] % 1000;
      wb(1'b1, `QPD_IDX_DIV, set_tab[i]);
      p0 = pos;
      mv(1'b1, 2 * m, 6);
      chk("ratio", p0 + 2 * (1 + n1), 32'(pos));
    end
    p0 = pos;
    mv(1'b0, 8, 6);
    chk("reverse", p0 - 4, 32'(pos));
    $display("ratio test done");
    wb(1'b1, `QPD_IDX_DIV, 16'h0005);
    foreach (bad_tab[i]) wb(1'b1, `QPD_IDX_DIV, bad_tab[i]);
    rc(`QPD_IDX_DIV, 32'h5, "div kept");
    // status also carries settled input levels and output phases (gray of the model count)
    rc(`QPD_IDX_STAT, 32'h10 | {28'h0, pos[1], pos[1] ^ pos[0], pb, pa}, "refused");
    wb(1'b1, `QPD_IDX_FILT, 16'h0010);
    rc(`QPD_IDX_FILT, 32'h0, "filt kept");
    wb(1'b1, `QPD_IDX_DIV, 16'h0080);
    wb(1'b1, `QPD_IDX_STEP, 16'h0001);
    rc(`QPD_IDX_DIV, 32'h3EA, "step up");
    wb(1'b1, `QPD_IDX_STEP, 16'h0002);
    rc(`QPD_IDX_DIV, 32'h80, "step down");
    wb(1'b1, `QPD_IDX_DIV, 16'h0468);
    wb(1'b1, `QPD_IDX_STEP, 16'h0001);
    rc(`QPD_IDX_DIV, 32'h468, "step top");
    wb(1'b1, `QPD_IDX_DIV, 16'h0001);
    wb(1'b1, `QPD_IDX_STEP, 16'h0002);
    rc(`QPD_IDX_DIV, 32'h1, "step bottom");
    $display("setting test done");
    wb(1'b1, `QPD_IDX_FILT, 16'h000F);
    rc(`QPD_IDX_FILT, 32'hF, "filt max");
    p0 = pos;
    @(posedge clk_i);
    pa <= ~pa;
    repeat (8) @(posedge clk_i);
    pa <= ~pa;
    repeat (40) @(posedge clk_i);
    chk("glitch", p0, 32'(pos));
    mv(1'b1, 4, 30);
    chk("filtered", p0 + 4, 32'(pos));
    $display("filter test done");
    finish_test();
  end
  initial
  begin
    repeat (50000) @(posedge clk_i);
    n_errors++;
    finish_test();
  end
endmodule : tb
